// >>> logic/scbs_pkg.sv
// constants shared by the sleep clock and brown-out status block
package scbs_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] OFF_RUN_CFG    = 8'h00;
    localparam logic [7:0] OFF_SLEEP_CFG  = 8'h04;
    localparam logic [7:0] OFF_RUN_GATE   = 8'h08;
    localparam logic [7:0] OFF_SLEEP_GATE = 8'h0C;
    localparam logic [7:0] OFF_BO_CTRL    = 8'h10;
    localparam logic [7:0] OFF_RAW        = 8'h14;
    localparam logic [7:0] OFF_MASK       = 8'h18;
    localparam logic [7:0] OFF_MASKED     = 8'h1C;
    localparam logic [7:0] OFF_STATUS     = 8'h20;
    // ==========================================
    // field layout
    localparam int CFG_W      = 9;
    localparam int CLK_W      = 8;
    localparam int OSC_PD_BIT = 8;
    localparam int GATE_W     = 16;
    localparam int BO_EN1_BIT = 0;
    localparam int BO_EN2_BIT = 1;
    localparam int IRQ_W      = 4;
    localparam int IRQ_BO     = 0;
    localparam int IRQ_BO_EVT = 1;
    localparam int IRQ_ASUP   = 2;
    localparam int IRQ_FALLBK = 3;
    // only these status bits can be unmasked and reach the masked status and irq
    localparam logic [IRQ_W-1:0] IRQ_LIVE = 4'h9;
    // ==========================================
    // reset values
    localparam logic [CFG_W-1:0]  RST_CFG        = 9'h000;
    localparam logic [GATE_W-1:0] RST_RUN_GATE   = 16'hFFFF;
    localparam logic [GATE_W-1:0] RST_SLEEP_GATE = 16'h0000;
    localparam logic [1:0]        RST_BO_CTRL    = 2'h2;
    // ==========================================
    // timing counts in system clock cycles
    localparam int              CNT_W         = 4;
    localparam logic [CNT_W-1:0] RESET_WINDOW = 4'hA;
    localparam logic [CNT_W-1:0] ENTRY_CYCLES = 4'hF;
    // ==========================================
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SEQ_RUN, SEQ_ENTER, SEQ_SLEEP} scbs_seq_e;
endpackage

// >>> logic/scbs_clk_if.sv
// signals between the register front end and the sleep sequencer
`timescale 1ns/1ps
interface scbs_clk_if;
    logic [scbs_pkg::CFG_W-1:0]  run_cfg;
    logic [scbs_pkg::CFG_W-1:0]  sleep_cfg;
    logic [scbs_pkg::GATE_W-1:0] run_gate;
    logic [scbs_pkg::GATE_W-1:0] sleep_gate;
    logic                        sleep_req;
    logic                        reset_evt;
    logic                        fallback_pend;
    logic                        in_sleep;
    logic                        fallback_used;
    logic [scbs_pkg::CLK_W-1:0]  clk_sel;
    logic                        osc_en;
    logic [scbs_pkg::GATE_W-1:0] gate;
    modport ctrl (output run_cfg, sleep_cfg, run_gate, sleep_gate, sleep_req, reset_evt,
                  input fallback_pend, in_sleep, fallback_used, clk_sel, osc_en, gate);
    modport seq  (input run_cfg, sleep_cfg, run_gate, sleep_gate, sleep_req, reset_evt,
                  output fallback_pend, in_sleep, fallback_used, clk_sel, osc_en, gate);
endinterface

// >>> logic/scbs_sync3.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module scbs_sync3 #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit moves only once stages two and three agree
    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    lvl_q[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
    endgenerate

    assign level = lvl_q;
endmodule

// >>> logic/scbs_sleep_seq.sv
// deep-sleep entry sequencer and clock configuration selector
`timescale 1ns/1ps
module scbs_sleep_seq (
    input  wire logic aclk,
    input  wire logic aresetn,
    scbs_clk_if.seq   cif
);
    scbs_pkg::scbs_seq_e             state_q;
    logic [scbs_pkg::CNT_W-1:0]      cnt_q;
    logic                            pend_q;
    logic                            active_q;
    logic                            used_q;
    logic [scbs_pkg::CLK_W-1:0]      clk_q;
    logic                            osc_q;
    logic [scbs_pkg::GATE_W-1:0]     gate_q;

    // ==========================================
    // entry sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= scbs_pkg::SEQ_RUN;
            cnt_q   <= '0;
        end else if (cif.reset_evt) begin
            state_q <= scbs_pkg::SEQ_RUN;
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                scbs_pkg::SEQ_RUN: begin
                    cnt_q <= '0;
                    if (cif.sleep_req) begin
                        state_q <= scbs_pkg::SEQ_ENTER;
                    end
                end
                scbs_pkg::SEQ_ENTER: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == scbs_pkg::ENTRY_CYCLES - 1'b1) begin
                        state_q <= scbs_pkg::SEQ_SLEEP;
                    end
                end
                scbs_pkg::SEQ_SLEEP: begin
                    if (!cif.sleep_req) begin
                        state_q <= scbs_pkg::SEQ_RUN;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // fallback bookkeeping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 1'b0;
        end else if (cif.reset_evt && state_q == scbs_pkg::SEQ_ENTER
                     && cnt_q < scbs_pkg::RESET_WINDOW) begin
            pend_q <= 1'b1;
        end else if (state_q == scbs_pkg::SEQ_SLEEP && active_q && !cif.sleep_req) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_q <= 1'b0;
            used_q   <= 1'b0;
        end else begin
            used_q <= 1'b0;
            if (state_q == scbs_pkg::SEQ_ENTER && cnt_q == scbs_pkg::ENTRY_CYCLES - 1'b1
                && !cif.reset_evt) begin
                active_q <= pend_q;
                used_q   <= pend_q;
            end else if (state_q != scbs_pkg::SEQ_SLEEP) begin
                active_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // clock outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_q  <= '0;
            osc_q  <= 1'b1;
            gate_q <= scbs_pkg::RST_RUN_GATE;
        end else if (state_q == scbs_pkg::SEQ_SLEEP) begin
            gate_q <= cif.sleep_gate;
            if (active_q) begin
                clk_q <= cif.run_cfg[scbs_pkg::CLK_W-1:0];
                osc_q <= !cif.run_cfg[scbs_pkg::OSC_PD_BIT];
            end else begin
                clk_q <= cif.sleep_cfg[scbs_pkg::CLK_W-1:0];
                osc_q <= !cif.sleep_cfg[scbs_pkg::OSC_PD_BIT];
            end
        end else begin
            clk_q  <= cif.run_cfg[scbs_pkg::CLK_W-1:0];
            osc_q  <= !cif.run_cfg[scbs_pkg::OSC_PD_BIT];
            gate_q <= cif.run_gate;
        end
    end

    assign cif.fallback_pend = pend_q;
    assign cif.in_sleep      = (state_q == scbs_pkg::SEQ_SLEEP);
    assign cif.fallback_used = used_q;
    assign cif.clk_sel       = clk_q;
    assign cif.osc_en        = osc_q;
    assign cif.gate          = gate_q;
endmodule

// >>> logic/scbs_top.sv
// sleep clock selection and brown-out status block with AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module scbs_top (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [31:0]                 s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [31:0]                 s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        brownout_detect,
    input  wire logic                        ext_reset_pin_n,
    input  wire logic                        wdog_reset_req,
    input  wire logic                        deep_sleep_req,
    output logic                             sys_reset_req,
    output logic [scbs_pkg::CLK_W-1:0]       sysclk_sel,
    output logic                             precise_internal_osc_en,
    output logic [scbs_pkg::GATE_W-1:0]      periph_clk_en,
    output logic                             in_deep_sleep,
    output logic                             irq
);
    scbs_clk_if cif ();

    // ==========================================
    // register state
    logic [scbs_pkg::CFG_W-1:0]  run_cfg_q;
    logic [scbs_pkg::CFG_W-1:0]  sleep_cfg_q;
    logic [scbs_pkg::GATE_W-1:0] run_gate_q;
    logic [scbs_pkg::GATE_W-1:0] sleep_clock_gating_reg_q;
    logic [1:0]                  brownout_control_reg_q;
    logic [scbs_pkg::IRQ_W-1:0]  raw_irq_status_reg_q;
    logic [scbs_pkg::IRQ_W-1:0]  irq_mask_control_reg_q;
    logic                        clear_armed_q;
    logic                        bo_lvl_q;
    logic                        rst_req_q;

    // ==========================================
    // bus state
    logic                        aw_have_q;
    logic                        w_have_q;
    logic [7:0]                  awaddr_q;
    logic [31:0]                 wdata_q;
    logic [3:0]                  wstrb_q;
    logic                        bvalid_q;
    logic [1:0]                  bresp_q;
    logic                        rvalid_q;
    logic [31:0]                 rdata_q;
    logic [1:0]                  rresp_q;
    logic                        wr_fire;
    logic                        rd_fire;
    logic [31:0]                 wval;
    logic [31:0]                 masked;
    logic [31:0]                 run_cfg_m;
    logic [31:0]                 sleep_cfg_m;
    logic [31:0]                 run_gate_m;
    logic [31:0]                 sleep_gate_m;

    // ==========================================
    // pin inputs
    logic [1:0]                  pins_lvl;
    logic                        bo_rise;
    logic                        ext_rst_lvl_q;
    logic                        ext_fall;
    logic                        bo_reset;
    logic                        reset_evt;

    scbs_sync3 #(.W(2)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({brownout_detect, !ext_reset_pin_n}),
        .level    (pins_lvl)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bo_lvl_q      <= 1'b0;
            ext_rst_lvl_q <= 1'b0;
        end else begin
            bo_lvl_q      <= pins_lvl[1];
            ext_rst_lvl_q <= pins_lvl[0];
        end
    end

    assign bo_rise   = pins_lvl[1] && !bo_lvl_q;
    assign ext_fall  = pins_lvl[0] && !ext_rst_lvl_q;
    // first enable bit is stored only
    assign bo_reset  = bo_rise && brownout_control_reg_q[scbs_pkg::BO_EN2_BIT];
    assign reset_evt = bo_reset || ext_fall || wdog_reset_req;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_req_q <= 1'b0;
        end else begin
            rst_req_q <= bo_reset || ext_fall || wdog_reset_req;
        end
    end

    // ==========================================
    // sleep sequencer
    assign cif.run_cfg    = run_cfg_q;
    assign cif.sleep_cfg  = sleep_cfg_q;
    assign cif.run_gate   = run_gate_q;
    assign cif.sleep_gate = sleep_clock_gating_reg_q;
    assign cif.sleep_req  = deep_sleep_req;
    assign cif.reset_evt  = reset_evt;

    scbs_sleep_seq u_seq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cif     (cif)
    );

    // ==========================================
    // write channel
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == scbs_pkg::OFF_RUN_CFG || a == scbs_pkg::OFF_SLEEP_CFG
            || a == scbs_pkg::OFF_RUN_GATE || a == scbs_pkg::OFF_SLEEP_GATE
            || a == scbs_pkg::OFF_BO_CTRL || a == scbs_pkg::OFF_RAW
            || a == scbs_pkg::OFF_MASK || a == scbs_pkg::OFF_MASKED
            || a == scbs_pkg::OFF_STATUS;
    endfunction

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
    assign wval          = merge(32'h0000_0000, wdata_q, wstrb_q);
    assign run_cfg_m     = merge({23'h0, run_cfg_q}, wdata_q, wstrb_q);
    assign sleep_cfg_m   = merge({23'h0, sleep_cfg_q}, wdata_q, wstrb_q);
    assign run_gate_m    = merge({16'h0, run_gate_q}, wdata_q, wstrb_q);
    assign sleep_gate_m  = merge({16'h0, sleep_clock_gating_reg_q}, wdata_q, wstrb_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr[7:2], 2'h0};
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= scbs_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(awaddr_q) ? scbs_pkg::RESP_OKAY : scbs_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ==========================================
    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_cfg_q                <= scbs_pkg::RST_CFG;
            sleep_cfg_q              <= scbs_pkg::RST_CFG;
            run_gate_q               <= scbs_pkg::RST_RUN_GATE;
            sleep_clock_gating_reg_q <= scbs_pkg::RST_SLEEP_GATE;
            brownout_control_reg_q   <= scbs_pkg::RST_BO_CTRL;
            irq_mask_control_reg_q   <= '0;
        end else if (wr_fire) begin
            unique case (awaddr_q)
                scbs_pkg::OFF_RUN_CFG: begin
                    run_cfg_q <= run_cfg_m[scbs_pkg::CFG_W-1:0];
                end
                scbs_pkg::OFF_SLEEP_CFG: begin
                    sleep_cfg_q <= sleep_cfg_m[scbs_pkg::CFG_W-1:0];
                end
                scbs_pkg::OFF_RUN_GATE: begin
                    run_gate_q <= run_gate_m[scbs_pkg::GATE_W-1:0];
                end
                scbs_pkg::OFF_SLEEP_GATE: begin
                    sleep_clock_gating_reg_q <= sleep_gate_m[scbs_pkg::GATE_W-1:0];
                end
                scbs_pkg::OFF_BO_CTRL: begin
                    if (wstrb_q[0]) begin
                        brownout_control_reg_q <= wdata_q[1:0];
                    end
                end
                scbs_pkg::OFF_MASK: begin
                    if (wstrb_q[0]) begin
                        // event and analog mask bits do not take writes
                        irq_mask_control_reg_q <= wdata_q[scbs_pkg::IRQ_W-1:0]
                                                  & scbs_pkg::IRQ_LIVE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // interrupt status
    logic clr_wr;
    assign clr_wr = wr_fire && awaddr_q == scbs_pkg::OFF_MASKED && wval[scbs_pkg::IRQ_BO];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clear_armed_q <= 1'b0;
        end else if (clr_wr) begin
            clear_armed_q <= !clear_armed_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_irq_status_reg_q <= '0;
        end else begin
            // set wins over a clear in the same cycle
            if (bo_rise) begin
                raw_irq_status_reg_q[scbs_pkg::IRQ_BO] <= 1'b1;
            end else if (clr_wr && clear_armed_q) begin
                raw_irq_status_reg_q[scbs_pkg::IRQ_BO] <= 1'b0;
            end
            if (bo_reset) begin
                raw_irq_status_reg_q[scbs_pkg::IRQ_BO_EVT] <= 1'b1;
            end
            raw_irq_status_reg_q[scbs_pkg::IRQ_ASUP] <= 1'b0;
            if (cif.fallback_used) begin
                raw_irq_status_reg_q[scbs_pkg::IRQ_FALLBK] <= 1'b1;
            end else if (wr_fire && awaddr_q == scbs_pkg::OFF_MASKED
                         && wval[scbs_pkg::IRQ_FALLBK]) begin
                raw_irq_status_reg_q[scbs_pkg::IRQ_FALLBK] <= 1'b0;
            end
        end
    end

    assign masked = {28'h0, raw_irq_status_reg_q & irq_mask_control_reg_q
                     & scbs_pkg::IRQ_LIVE};
    assign irq    = |masked;

    // ==========================================
    // read channel
    assign s_axi_arready = !rvalid_q;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= scbs_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= scbs_pkg::RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'h0})
                scbs_pkg::OFF_RUN_CFG:    rdata_q <= {23'h0, run_cfg_q};
                scbs_pkg::OFF_SLEEP_CFG:  rdata_q <= {23'h0, sleep_cfg_q};
                scbs_pkg::OFF_RUN_GATE:   rdata_q <= {16'h0, run_gate_q};
                scbs_pkg::OFF_SLEEP_GATE: rdata_q <= {16'h0, sleep_clock_gating_reg_q};
                scbs_pkg::OFF_BO_CTRL:    rdata_q <= {30'h0, brownout_control_reg_q};
                scbs_pkg::OFF_RAW:        rdata_q <= {28'h0, raw_irq_status_reg_q};
                scbs_pkg::OFF_MASK:       rdata_q <= {28'h0, irq_mask_control_reg_q};
                scbs_pkg::OFF_MASKED:     rdata_q <= masked;
                scbs_pkg::OFF_STATUS: begin
                    rdata_q <= {28'h0, bo_lvl_q, clear_armed_q, cif.in_sleep,
                                cif.fallback_pend};
                end
                default: begin
                    rdata_q <= '0;
                    rresp_q <= scbs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================
    // outputs
    assign s_axi_bvalid            = bvalid_q;
    assign s_axi_bresp             = bresp_q;
    assign s_axi_rvalid            = rvalid_q;
    assign s_axi_rdata             = rdata_q;
    assign s_axi_rresp             = rresp_q;
    assign sys_reset_req           = rst_req_q;
    assign sysclk_sel              = cif.clk_sel;
    assign precise_internal_osc_en = cif.osc_en;
    assign periph_clk_en           = cif.gate;
    assign in_deep_sleep           = cif.in_sleep;
endmodule

// >>> verif/scbs_checker.sv
// port assertions for the sleep clock and brown-out block
`timescale 1ns/1ps
module scbs_checker (
    input logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input logic        s_axi_arready, s_axi_rvalid, s_axi_rready, deep_sleep_req,
    input logic        sys_reset_req, in_deep_sleep, irq, precise_internal_osc_en,
    input logic [1:0]  s_axi_bresp,
    input logic [15:0] periph_clk_en
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("no bvalid");
    AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid) else $error("no rvalid");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    AST_RST_PULSE: assert property (sys_reset_req |=> !sys_reset_req)
        else $error("reset request too long");
    AST_WAKE: assert property (in_deep_sleep && !deep_sleep_req |-> ##[1:3] !in_deep_sleep)
        else $error("no wake");
    AST_ENTRY: assert property ($rose(in_deep_sleep) |-> $past(deep_sleep_req, 8))
        else $error("sleep without entry");
    AST_RST_STATE: assert property (disable iff (1'b0) !aresetn |=> !in_deep_sleep && !irq
        && precise_internal_osc_en && periph_clk_en == 16'hFFFF) else $error("reset state");
endmodule
bind scbs_top scbs_checker u_chk (.*);

// >>> verif/scbs_top_bench.sv
// self-checking bench for the sleep clock and brown-out block
`timescale 1ns/1ps
module scbs_top_bench;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bo_det, ext_n;
    logic        wdog, sleep_req, rst_req, osc_en, in_sleep, irq;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0]  bresp, rresp;
    logic [7:0]  clk_sel;
    logic [15:0] gate;
    int          fail_count = 0, total_checks = 0, cycles = 0, rst_seen = 0;
    scbs_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .brownout_detect(bo_det), .ext_reset_pin_n(ext_n), .wdog_reset_req(wdog),
        .deep_sleep_req(sleep_req), .sys_reset_req(rst_req), .sysclk_sel(clk_sel),
        .precise_internal_osc_en(osc_en), .periph_clk_en(gate), .in_deep_sleep(in_sleep),
        .irq(irq));
    initial begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (rst_req === 1'b1) rst_seen <= rst_seen + 1;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= {24'h0, a}; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= {24'h0, a}; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rready <= 0;
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    task automatic pulse_bo();
        bo_det <= 1;
        repeat (6) @(posedge aclk);
        bo_det <= 0;
        repeat (8) @(posedge aclk);
    endtask
    task automatic wait_sleep(input logic lvl);
        do @(posedge aclk); while (in_sleep !== lvl);
        repeat (2) @(posedge aclk);
    endtask
    initial begin
        aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; wdata = 0; araddr = 0; bo_det = 0; ext_n = 1; wdog = 0; sleep_req = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(8'h08, 32'hFFFF, 0);
        rd(8'h0C, 0, 0);
        rd(8'h10, 2, 0);
        rd(8'h3C, 0, 2'h2);
        wr(8'h3C, 1, 2'h2);
        wr(8'h18, 32'hF, 0);
        rd(8'h18, 32'h9, 0);
        wr(8'h10, 1, 0);
        pulse_bo();
        chk(rst_seen, 0);
        rd(8'h14, 1, 0);
        chk({31'h0, irq}, 1);
        wr(8'h1C, 0, 0);
        rd(8'h14, 1, 0);
        wr(8'h1C, 1, 0);
        rd(8'h14, 1, 0);
        wr(8'h1C, 1, 0);
        rd(8'h14, 0, 0);
        chk({31'h0, irq}, 0);
        wr(8'h10, 2, 0);
        pulse_bo();
        chk(rst_seen, 1);
        rd(8'h14, 3, 0);
        wr(8'h00, 32'h0AB, 0);
        wr(8'h04, 32'h155, 0);
        wr(8'h0C, 32'hF0, 0);
        sleep_req <= 1;
        repeat (3) @(posedge aclk);
        wdog <= 1;
        @(posedge aclk);
        wdog <= 0;
        wait_sleep(1);
        chk({7'h0, clk_sel, osc_en, gate}, {7'h0, 8'hAB, 1'b1, 16'hF0});
        sleep_req <= 0;
        wait_sleep(0);
        sleep_req <= 1;
        wait_sleep(1);
        chk({7'h0, clk_sel, osc_en, gate}, {7'h0, 8'h55, 1'b0, 16'hF0});
        sleep_req <= 0;
        wait_sleep(0);
        rd(8'h1C, 32'h9, 0);
        wr(8'h1C, 32'h8, 0);
        rd(8'h14, 32'h3, 0);
        ext_n <= 0;
        repeat (8) @(posedge aclk);
        ext_n <= 1;
        chk(rst_seen, 3);
        stop_test();
    end
endmodule
